// ===== design/rtr_defines.svh
/*
 * Offsets, field positions, reset values and widths of the remote target address
 * remap table slice.
 * Assumes inclusion by bare name from any design or bench file.
 */
`ifndef RTR_DEFINES_SVH
`define RTR_DEFINES_SVH

`define RTR_PORT_SEL_OFFSET 8'h4c
`define RTR_ENTRY0_OFFSET 8'h5d
`define RTR_ENTRY1_OFFSET 8'h5e
`define RTR_ENTRY2_OFFSET 8'h5f
`define RTR_ENTRY3_OFFSET 8'h60
`define RTR_ENTRY4_OFFSET 8'h61
`define RTR_ADDR_MSB 7
`define RTR_ADDR_LSB 1
`define RTR_RSVD_BIT 0
`define RTR_ADDR_RESET 7'h00
`define RTR_NUM_PORTS 4
`define RTR_NUM_ENTRIES 5

`endif

// ===== design/rtr_pkg.sv
/*
 * Types shared by the remap table slice.
 * Assumes rtr_defines.svh is available on the include path.
 */
`include "rtr_defines.svh"

package rtr_pkg;
   typedef logic [6:0] rtr_addr_t;
   typedef logic [7:0] rtr_byte_t;
   typedef logic [1:0] rtr_port_t;
   typedef logic [2:0] rtr_entry_t;
endpackage

// ===== design/rtr_tbl_if.sv
/*
 * Write/read carrier between the register decoder and the per-port table.
 * Assumes a single clock domain shared by both ends.
 */
`timescale 1ns/10ps

interface rtr_tbl_if;
   logic wr_en;
   rtr_pkg::rtr_port_t wr_port;
   rtr_pkg::rtr_entry_t wr_entry;
   rtr_pkg::rtr_addr_t wr_addr;
   rtr_pkg::rtr_port_t rd_port;
   rtr_pkg::rtr_entry_t rd_entry;
   rtr_pkg::rtr_addr_t rd_addr;
   rtr_pkg::rtr_port_t map_port;
   rtr_pkg::rtr_entry_t map_entry;
   rtr_pkg::rtr_addr_t map_addr;

   modport ctrl (output wr_en, output wr_port, output wr_entry, output wr_addr,
                 output rd_port, output rd_entry, input rd_addr,
                 output map_port, output map_entry, input map_addr);
   modport table_end (input wr_en, input wr_port, input wr_entry, input wr_addr,
                      input rd_port, input rd_entry, output rd_addr,
                      input map_port, input map_entry, output map_addr);
endinterface

// ===== design/rtr_table.sv
/*
 * Storage of physical target addresses, one copy per receive port and entry.
 * Assumes writes arrive as single-cycle strobes on the interface.
 */
`timescale 1ns/10ps
`include "rtr_defines.svh"

module rtr_table (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Table access.
   rtr_tbl_if.table_end tbl
);

   rtr_pkg::rtr_addr_t mem_q [`RTR_NUM_PORTS][`RTR_NUM_ENTRIES];
   rtr_pkg::rtr_addr_t mem_d [`RTR_NUM_PORTS][`RTR_NUM_ENTRIES];

   // -------------------------------------------------------------------
   // Per-port copies of each entry.
   // -------------------------------------------------------------------
   genvar p;
   genvar e;
   generate
      for (p = 0; p < `RTR_NUM_PORTS; p++) begin : g_port
         for (e = 0; e < `RTR_NUM_ENTRIES; e++) begin : g_ent
            always_comb begin
               mem_d[p][e] = mem_q[p][e];
               if (tbl.wr_en && tbl.wr_port == 2'(p) && tbl.wr_entry == 3'(e)) begin
                  mem_d[p][e] = tbl.wr_addr;
               end
            end
            always_ff @(posedge clock or negedge rst_n) begin
               if (!rst_n) begin
                  mem_q[p][e] <= `RTR_ADDR_RESET;
               end else begin
                  mem_q[p][e] <= mem_d[p][e];
               end
            end
         end
      end
   endgenerate

   assign tbl.rd_addr = mem_q[tbl.rd_port][tbl.rd_entry];
   assign tbl.map_addr = mem_q[tbl.map_port][tbl.map_entry];

endmodule // rtr_table

// ===== design/rtr_remap.sv
/*
 * Remote target address remap slice: register decode for entries 0 to 4 of the
 * per-port table, and address substitution on alias match.
 * Assumes the register access port and the alias matcher run on clock.
 */
`timescale 1ns/10ps
`include "rtr_defines.svh"

// Overview of operation
// - Per-port copies, selected by port select register for register access and by fwd_port for forwarding.
// - Entry 2 address at 0x5F, bits 7:1.
// - Alias 2 hit forwards stored entry-2 address.
// - Entry 3 address at 0x60, bits 7:1.
// - Alias 3 hit forwards stored entry-3 address.
// - Entry 4 register at offset 0x61.
// - Entries 0 and 1 at 0x5D, 0x5E.

module rtr_remap (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register access port.
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire rtr_pkg::rtr_byte_t reg_offset,
   input wire rtr_pkg::rtr_byte_t reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Port select register value.
   input wire rtr_pkg::rtr_port_t port_sel,
   // Forwarding path.
   input wire logic fwd_valid,
   input wire rtr_pkg::rtr_port_t fwd_port,
   input wire logic alias_hit,
   input wire rtr_pkg::rtr_entry_t alias_index,
   input wire rtr_pkg::rtr_addr_t fwd_addr_in,
   output logic fwd_out_valid,
   output logic [6:0] fwd_addr_out
);

   rtr_tbl_if tbl ();
   logic dec_hit;
   rtr_pkg::rtr_entry_t dec_entry;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic hit_d;
   logic hit_q;
   logic [6:0] fwd_d;
   logic [6:0] fwd_q;
   logic fv_d;
   logic fv_q;

   // -------------------------------------------------------------------
   // Per-port table storage.
   // -------------------------------------------------------------------
   rtr_table u_table (
      .clock(clock),
      .rst_n(rst_n),
      .tbl(tbl)
   );

   // -------------------------------------------------------------------
   // Offset decode.
   // -------------------------------------------------------------------
   always_comb begin
      dec_hit = 1'b1;
      dec_entry = 3'h0;
      unique case (reg_offset)
         `RTR_ENTRY0_OFFSET: dec_entry = 3'h0;
         `RTR_ENTRY1_OFFSET: dec_entry = 3'h1;
         `RTR_ENTRY2_OFFSET: dec_entry = 3'h2;
         `RTR_ENTRY3_OFFSET: dec_entry = 3'h3;
         `RTR_ENTRY4_OFFSET: dec_entry = 3'h4;
         default: dec_hit = 1'b0;
      endcase
   end

   assign tbl.wr_en = reg_wr && dec_hit;
   assign tbl.wr_port = port_sel;
   assign tbl.wr_entry = dec_entry;
   assign tbl.wr_addr = reg_wdata[`RTR_ADDR_MSB:`RTR_ADDR_LSB];
   assign tbl.rd_port = port_sel;
   assign tbl.rd_entry = dec_entry;
   assign tbl.map_port = fwd_port;
   assign tbl.map_entry = alias_index;

   // -------------------------------------------------------------------
   // Read data register.
   // -------------------------------------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      hit_d = 1'b0;
      if (reg_rd) begin
         hit_d = dec_hit;
         rdata_d = dec_hit ? {tbl.rd_addr, 1'b0} : 8'h00;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         hit_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         hit_q <= hit_d;
      end
   end

   // -------------------------------------------------------------------
   // Forwarded address register.
   // -------------------------------------------------------------------
   always_comb begin
      fv_d = fwd_valid;
      fwd_d = fwd_q;
      if (fwd_valid) begin
         if (alias_hit) begin
            fwd_d = tbl.map_addr;
         end else begin
            fwd_d = fwd_addr_in;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fwd_q <= 7'h00;
         fv_q <= 1'b0;
      end else begin
         fwd_q <= fwd_d;
         fv_q <= fv_d;
      end
   end

   // -------------------------------------------------------------------
   // Output drive.
   // -------------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign reg_hit = hit_q;
   assign fwd_addr_out = fwd_q;
   assign fwd_out_valid = fv_q;

endmodule // rtr_remap

// ===== bench/rtr_remote_sink.sv
/* Remote serializer side: keeps the last forwarded target address.
   Assumes a one-cycle forward strobe on clock. */
`timescale 1ns/10ps
module rtr_remote_sink (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic fwd_out_valid,
   input wire logic [6:0] fwd_addr_out,
   output logic [6:0] last_addr
);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) last_addr <= 7'h00;
      else if (fwd_out_valid) last_addr <= fwd_addr_out;
   end
endmodule // rtr_remote_sink

// ===== bench/rtr_remap_asserts.sv
/* Port checker for the remap slice.
   Assumes it is bound to rtr_remap. */
`timescale 1ns/10ps
`include "rtr_defines.svh"
module rtr_remap_asserts (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register access port.
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire rtr_pkg::rtr_byte_t reg_offset,
   input wire rtr_pkg::rtr_byte_t reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // Port select register value.
   input wire rtr_pkg::rtr_port_t port_sel,
   // Forwarding path.
   input wire logic fwd_valid,
   input wire rtr_pkg::rtr_port_t fwd_port,
   input wire logic alias_hit,
   input wire rtr_pkg::rtr_entry_t alias_index,
   input wire rtr_pkg::rtr_addr_t fwd_addr_in,
   input wire logic fwd_out_valid,
   input wire logic [6:0] fwd_addr_out
);
   wire mapped = reg_offset inside {[`RTR_ENTRY0_OFFSET:`RTR_ENTRY4_OFFSET]};
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_HIT: assert property (reg_rd && mapped |=> reg_hit) else $error("no hit");
   AST_MISS: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
      else $error("unmapped read answered");
   AST_BIT0: assert property (reg_hit |-> !reg_rdata[0]) else $error("bit 0 set");
   AST_RDHOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("data moved");
   AST_WRRD: assert property (reg_wr && mapped ##1 !reg_wr ##1 reg_rd
      && reg_offset == $past(reg_offset, 2) && port_sel == $past(port_sel, 2)
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'hfe)) else $error("readback differs");
   AST_FWDV: assert property (##1 fwd_out_valid == $past(fwd_valid)) else $error("valid");
   AST_PASS: assert property (fwd_valid && !alias_hit |=> fwd_addr_out == $past(fwd_addr_in))
      else $error("miss changed address");
   AST_HOLD: assert property (!fwd_valid |=> $stable(fwd_addr_out)) else $error("addr moved");
endmodule // rtr_remap_asserts
bind rtr_remap rtr_remap_asserts u_chk (
   .clock(clock),
   .rst_n(rst_n),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_offset(reg_offset),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .reg_hit(reg_hit),
   .port_sel(port_sel),
   .fwd_valid(fwd_valid),
   .fwd_port(fwd_port),
   .alias_hit(alias_hit),
   .alias_index(alias_index),
   .fwd_addr_in(fwd_addr_in),
   .fwd_out_valid(fwd_out_valid),
   .fwd_addr_out(fwd_addr_out)
);

// ===== bench/tb_top.sv
/* Bench for the remap slice with a remote sink model.
   Assumes design and sink are compiled first. */
`timescale 1ns/10ps
module tb_top;
   logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fwd_valid = 1'b0;
   logic alias_hit = 1'b0, reg_hit, fwd_out_valid;
   logic [7:0] reg_offset = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [1:0] port_sel = 2'h0, fwd_port = 2'h0;
   logic [2:0] alias_index = 3'h0;
   logic [6:0] fwd_addr_in = 7'h00, fwd_addr_out, sink_addr;
   int errors = 0, num_checks = 0;
   always #5 clock = ~clock;
   rtr_remap u_dut (
      .clock(clock),
      .rst_n(rst_n),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_offset(reg_offset),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .reg_hit(reg_hit),
      .port_sel(port_sel),
      .fwd_valid(fwd_valid),
      .fwd_port(fwd_port),
      .alias_hit(alias_hit),
      .alias_index(alias_index),
      .fwd_addr_in(fwd_addr_in),
      .fwd_out_valid(fwd_out_valid),
      .fwd_addr_out(fwd_addr_out)
   );
   rtr_remote_sink u_sink (.clock(clock), .rst_n(rst_n), .fwd_out_valid(fwd_out_valid),
      .fwd_addr_out(fwd_addr_out), .last_addr(sink_addr));
   function automatic logic [7:0] ev(int p, int e);
      return {1'b1, 2'(p), 3'(e), 2'b01};
   endfunction
   task automatic chk(logic [8:0] got, logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] off, logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_offset <= off;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] off, logic [7:0] exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_offset <= off;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk({reg_hit, reg_rdata}, {off inside {[8'h5d:8'h61]}, exp});
   endtask
   task automatic fwd(int p, logic hit, int e, logic [7:0] exp);
      @(posedge clock);
      fwd_valid <= 1'b1;
      fwd_port <= 2'(p);
      alias_hit <= hit;
      alias_index <= 3'(e);
      fwd_addr_in <= 7'h2a;
      @(posedge clock);
      fwd_valid <= 1'b0;
      @(posedge clock);
      #1;
      chk({2'h0, sink_addr}, {1'b0, exp});
   endtask
   task automatic t_reset;
      for (int o = 8'h5c; o <= 8'h62; o++) rd(8'(o), 8'h00);
      wr(8'h5f, 8'ha5);
      rd(8'h5f, 8'ha4);
   endtask
   task automatic t_table;
      for (int p = 0; p < 4; p++) begin
         @(posedge clock);
         port_sel <= 2'(p);
         for (int e = 0; e < 5; e++) wr(8'(8'h5d + e), ev(p, e));
      end
      for (int p = 0; p < 4; p++) begin
         @(posedge clock);
         port_sel <= 2'(p);
         for (int e = 0; e < 5; e++) rd(8'(8'h5d + e), ev(p, e) & 8'hfe);
      end
      wr(8'h62, 8'hff);
      rd(8'h62, 8'h00);
   endtask
   task automatic t_fwd;
      @(posedge clock);
      port_sel <= 2'h0;
      for (int p = 0; p < 4; p++) begin
         fwd(p, 1'b1, 2, ev(p, 2) >> 1);
         fwd(p, 1'b1, 3, ev(p, 3) >> 1);
         fwd(p, 1'b0, 3, 8'h2a);
      end
   endtask
   task automatic t_rst_mid;
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      for (int e = 0; e < 5; e++) rd(8'(8'h5d + e), 8'h00);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #50000;
      errors++;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      t_reset;
      t_table;
      t_fwd;
      t_rst_mid;
      end_sim;
   end
endmodule // tb_top
